// file: pkg/trc_pkg.sv
package trc_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_FLAGS = 4'hc;

  // Control register fields
  localparam int CTRL_CLEAR_BIT = 0;

  // Status and mask register fields
  localparam int EV_PARITY_BIT = 0;
  localparam int EV_UNTRANS_BIT = 1;
  localparam int EV_AUX_FAULT_BIT = 2;
  localparam int EV_PURGE_BIT = 3;
  localparam int EV_WIDTH = 4;

  // Flag register fields
  localparam int FL_POS_BIT = 0;
  localparam int FL_RW_BIT = 1;
  localparam int FL_PDIAG_BIT = 2;
  localparam int FL_UDIAG_BIT = 3;
  localparam int FL_HOLD_P_BIT = 4;
  localparam int FL_HOLD_U_BIT = 5;
  localparam int FL_WIDTH = 6;

  // Reset values
  localparam logic [EV_WIDTH-1:0] MASK_RST = 4'h0;
  localparam logic [EV_WIDTH-1:0] STATUS_RST = 4'h0;

  // Translator codes
  localparam logic [4:0] PLUS_CODE = 5'h07;
  localparam logic [3:0] XS3_DIGIT_LO = 4'h3;
  localparam logic [3:0] XS3_DIGIT_HI = 4'hc;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// file: src/trc_char_checker.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] Parity check runs on every character of every read cycle, any mode.
// [RULE2] A seven-bit character is valid only with an odd count of ones.
// [RULE3] Bits 1-3 and 4-6 decode to even/odd pairs, combined with bit 7.
// [RULE4] Accept if bit 7 set and equal group parity, or clear and differing.
// [RULE5] Flag decoder fault when both outputs low, or both inverses low.
// [RULE6] Decoder fault jams a group pair to one state, forcing parity error.
// [RULE7] Untranslatable gate enabled only while one-digit translate is present.
// [RULE8] Digits, minus, space, plus, period, ignore pass; others are untranslatable.
// [RULE9] In hash period, errors latch into separate hold flags only.
// [RULE10] Held errors classified as information set error and diagnostic flags.
// [RULE11] Held pulses classified as hash clear hold flags and purge buffer.
// [RULE12] Outside hash period, parity error sets positioner flag when attached.
// [RULE13] Outside hash period, unattached, parity error sets read-write flag.
// [RULE14] Parity sets its diagnostic flag; both diagnostics blocked in hash period.
// [RULE15] Untranslatable outside hash period sets its diagnostic flag.
// [RULE16] Untranslatable character substitutes the plus code 00111.
// [RULE17] No untranslatable check during check-read operations.
// [RULE18] Error and diagnostic flags stay set until a clear sequence.
module trc_char_checker #(
  parameter logic [5:0] MINUS_CODE = 6'h01,
  parameter logic [5:0] SPACE_CODE = 6'h02,
  parameter logic [5:0] PLUS_CODE6 = 6'h10,
  parameter logic [5:0] PERIOD_CODE = 6'h20,
  parameter logic [5:0] IGNORE_CODE = 6'h30
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Read cycle side
  input wire logic char_valid,
  input wire logic [6:0] char_in,
  input wire logic char_check_bit,
  input wire logic aux_decode_a,
  input wire logic aux_decode_b,
  input wire logic one_digit_xlat,
  input wire logic check_read,
  input wire logic [4:0] xlat_in,
  input wire logic hash_pulse_period,
  input wire logic positioner_attached,
  input wire logic classify_info,
  input wire logic classify_hash,
  input wire logic flag_clear,
  output logic [4:0] xlat_out,
  output logic parity_err,
  output logic untrans_err,
  output logic aux_fault_both_low,
  output logic aux_fault_both_high,
  output logic hash_purge,
  output logic parity_err_to_positioner,
  output logic parity_err_to_rw_flag,
  output logic parity_diag_err,
  output logic untrans_diag_err,
  output logic irq,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // Two legal symbols sharing one code would hide an untranslatable character
  if (MINUS_CODE == SPACE_CODE) begin : g_bad_codes
    $error("trc_char_checker: minus and space codes must differ");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Character classification

  function automatic logic one_digit_ok(input logic [5:0] c);
    logic digit;
    digit = (c[5:4] == 2'b00) && (c[3:0] >= trc_pkg::XS3_DIGIT_LO) && (c[3:0] <= trc_pkg::XS3_DIGIT_HI);
    one_digit_ok = digit || (c == MINUS_CODE) || (c == SPACE_CODE) || (c == PLUS_CODE6) ||
                   (c == PERIOD_CODE) || (c == IGNORE_CODE);
  endfunction

  logic low_group_even;
  logic low_group_odd;
  logic high_group_even;
  logic high_group_odd;
  logic aux_fault;
  logic parity_ok;
  logic parity_hit;
  logic untrans_hit;

  // [RULE5] decoder consistency
  assign aux_fault = ~(aux_decode_a ^ aux_decode_b);

  always_comb begin
    // [RULE3] group decoders
    low_group_even = ~^char_in[2:0];
    low_group_odd = ^char_in[2:0];
    high_group_even = ~^char_in[5:3];
    high_group_odd = ^char_in[5:3];
    // [RULE6] jam low pair together
    if (aux_fault) begin
      low_group_even = 1'b0;
      low_group_odd = 1'b0;
    end
  end

  // [RULE2] odd count of ones
  // [RULE4] group parity against check bit
  assign parity_ok = (char_check_bit & ((low_group_even & high_group_even) | (low_group_odd & high_group_odd))) |
                     (~char_check_bit & ((low_group_odd & high_group_even) | (low_group_even & high_group_odd)));

  // [RULE1] every read cycle
  assign parity_hit = char_valid & ~parity_ok;

  // [RULE7] gated by one-digit translate
  // [RULE8] legal one-digit characters
  // [RULE17] skipped in check-read
  assign untrans_hit = char_valid & one_digit_xlat & ~check_read & ~one_digit_ok(char_in[5:0]);

  //////////////////////////////////////////////////////////////////////////////
  // Per-cycle outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_err <= 1'b0;
      untrans_err <= 1'b0;
      aux_fault_both_low <= 1'b0;
      aux_fault_both_high <= 1'b0;
      xlat_out <= 5'h00;
    end else if (ce) begin
      parity_err <= parity_hit;
      untrans_err <= untrans_hit;
      aux_fault_both_low <= char_valid & ~aux_decode_a & ~aux_decode_b;
      aux_fault_both_high <= char_valid & aux_decode_a & aux_decode_b;
      if (char_valid) begin
        // [RULE16] plus code substitution
        xlat_out <= untrans_hit ? trc_pkg::PLUS_CODE : xlat_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error distribution

  logic hold_parity_r;
  logic hold_untrans_r;
  logic sw_clear;
  logic clr_all;
  logic rel_parity;
  logic rel_untrans;
  logic live_parity;
  logic live_untrans;

  assign clr_all = flag_clear | sw_clear;
  assign rel_parity = classify_info & hold_parity_r;
  assign rel_untrans = classify_info & hold_untrans_r;
  assign live_parity = parity_hit & ~hash_pulse_period;
  assign live_untrans = untrans_hit & ~hash_pulse_period;

  // [RULE9] hold flags in hash period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_parity_r <= 1'b0;
      hold_untrans_r <= 1'b0;
    end else if (ce) begin
      if (parity_hit & hash_pulse_period) begin
        hold_parity_r <= 1'b1;
      end else if (classify_info | classify_hash | clr_all) begin
        // [RULE11] hash clears holds
        hold_parity_r <= 1'b0;
      end
      if (untrans_hit & hash_pulse_period) begin
        hold_untrans_r <= 1'b1;
      end else if (classify_info | classify_hash | clr_all) begin
        hold_untrans_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hash_purge <= 1'b0;
    end else if (ce) begin
      // [RULE11] purge hash characters
      hash_purge <= classify_hash;
    end
  end

  logic err_set;

  // [RULE10] released errors join live ones
  assign err_set = live_parity | rel_parity | rel_untrans;

  // Flags hold until cleared; a set in the clear cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_err_to_positioner <= 1'b0;
      parity_err_to_rw_flag <= 1'b0;
      parity_diag_err <= 1'b0;
      untrans_diag_err <= 1'b0;
    end else if (ce) begin
      // [RULE12] positioner attached
      if (err_set & positioner_attached) begin
        parity_err_to_positioner <= 1'b1;
      end else if (clr_all) begin
        // [RULE18] held until cleared
        parity_err_to_positioner <= 1'b0;
      end
      // [RULE13] no positioner attached
      if (err_set & ~positioner_attached) begin
        parity_err_to_rw_flag <= 1'b1;
      end else if (clr_all) begin
        parity_err_to_rw_flag <= 1'b0;
      end
      // [RULE14] diagnostic blocked in hash period
      if (live_parity | rel_parity) begin
        parity_diag_err <= 1'b1;
      end else if (clr_all) begin
        parity_diag_err <= 1'b0;
      end
      // [RULE15] untranslatable diagnostic
      if (live_untrans | rel_untrans) begin
        untrans_diag_err <= 1'b1;
      end else if (clr_all) begin
        untrans_diag_err <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave

  logic dp_write_r;
  logic [3:0] dp_addr_r;
  logic addr_take;
  logic [trc_pkg::EV_WIDTH-1:0] status_r;
  logic [trc_pkg::EV_WIDTH-1:0] mask_r;
  logic [trc_pkg::EV_WIDTH-1:0] ev_set;
  logic [trc_pkg::FL_WIDTH-1:0] flags_view;
  logic status_read;

  // Wait states follow the clock enable, so no transfer slips past a frozen cycle
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign addr_take = ce & hready & hsel & (htrans == trc_pkg::HTRANS_NONSEQ) & (hsize == trc_pkg::HSIZE_WORD) &
                     (haddr[31:4] == 28'h0000000);
  assign status_read = addr_take & ~hwrite & (haddr[3:0] == trc_pkg::OFS_STATUS);
  assign sw_clear = ce & dp_write_r & (dp_addr_r == trc_pkg::OFS_CTRL) & hwdata[trc_pkg::CTRL_CLEAR_BIT];

  assign flags_view = {hold_untrans_r, hold_parity_r, untrans_diag_err, parity_diag_err,
                       parity_err_to_rw_flag, parity_err_to_positioner};

  always_comb begin
    ev_set = '0;
    ev_set[trc_pkg::EV_PARITY_BIT] = parity_hit;
    ev_set[trc_pkg::EV_UNTRANS_BIT] = untrans_hit;
    ev_set[trc_pkg::EV_AUX_FAULT_BIT] = char_valid & aux_fault;
    ev_set[trc_pkg::EV_PURGE_BIT] = classify_hash;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_write_r <= 1'b0;
      dp_addr_r <= 4'h0;
    end else if (ce) begin
      dp_write_r <= addr_take & hwrite;
      dp_addr_r <= haddr[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_take & ~hwrite) begin
      unique case (haddr[3:0])
        trc_pkg::OFS_STATUS: hrdata <= {28'h0000000, status_r};
        trc_pkg::OFS_MASK: hrdata <= {28'h0000000, mask_r};
        trc_pkg::OFS_FLAGS: hrdata <= {26'h0, flags_view};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= trc_pkg::MASK_RST;
    end else if (ce & dp_write_r & (dp_addr_r == trc_pkg::OFS_MASK)) begin
      mask_r <= hwdata[trc_pkg::EV_WIDTH-1:0];
    end
  end

  // Read clears status; events in the same cycle survive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= trc_pkg::STATUS_RST;
    end else if (ce) begin
      status_r <= (status_read ? '0 : status_r) | ev_set;
    end
  end

  assign irq = |(status_r & mask_r);

endmodule // trc_char_checker

// file: testbench/trc_char_checker_monitor.sv
`timescale 1ns/1ps

module trc_char_checker_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic char_valid,
  input wire logic [6:0] char_in,
  input wire logic char_check_bit,
  input wire logic aux_decode_a,
  input wire logic aux_decode_b,
  input wire logic one_digit_xlat,
  input wire logic check_read,
  input wire logic hash_pulse_period,
  input wire logic positioner_attached,
  input wire logic classify_info,
  input wire logic classify_hash,
  input wire logic flag_clear,
  input wire logic hsel,
  input wire logic [4:0] xlat_out,
  input wire logic parity_err,
  input wire logic untrans_err,
  input wire logic aux_fault_both_low,
  input wire logic aux_fault_both_high,
  input wire logic hash_purge,
  input wire logic parity_err_to_positioner,
  input wire logic parity_err_to_rw_flag,
  input wire logic parity_diag_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    ce && char_valid;
  endsequence
  sequence s_hash_take;
    s_take ##0 hash_pulse_period && !classify_info && !parity_diag_err;
  endsequence
  chk_parity_rule: assert property (s_take |=>
    parity_err == $past(~^{char_check_bit, char_in[5:0]} || aux_decode_a == aux_decode_b))
    else $error("parity error output wrong");
  chk_fault_low: assert property (s_take ##0 !aux_decode_a && !aux_decode_b |=>
    aux_fault_both_low && parity_err) else $error("both-low decoder fault missed");
  chk_fault_high: assert property (s_take ##0 aux_decode_a && aux_decode_b |=>
    aux_fault_both_high && parity_err) else $error("both-high decoder fault missed");
  chk_untrans_off: assert property (s_take ##0 (!one_digit_xlat || check_read) |=>
    !untrans_err) else $error("untranslatable check not gated");
  chk_plus_subst: assert property (untrans_err |->
    xlat_out == trc_pkg::PLUS_CODE) else $error("plus code not substituted");
  chk_hash_block: assert property (s_hash_take |=> !parity_diag_err)
    else $error("diagnostic set in hash period");
  chk_pos_route: assert property (parity_err && !$past(hash_pulse_period)
    && $past(positioner_attached) |-> parity_err_to_positioner) else $error("positioner flag missed");
  chk_rw_route: assert property (parity_err && !$past(hash_pulse_period)
    && !$past(positioner_attached) |-> parity_err_to_rw_flag && parity_diag_err) else $error("rw flag missed");
  chk_purge_pulse: assert property (ce && classify_hash |=> hash_purge)
    else $error("purge pulse missing");
  chk_flag_sticky: assert property (parity_diag_err && !flag_clear && !hsel && !$past(hsel) |=>
    parity_diag_err) else $error("diagnostic flag dropped");
endmodule // trc_char_checker_monitor

bind trc_char_checker trc_char_checker_monitor u_mon (.clk, .rst, .ce, .char_valid, .char_in, .char_check_bit,
  .aux_decode_a, .aux_decode_b, .one_digit_xlat, .check_read, .hash_pulse_period, .positioner_attached,
  .classify_info, .classify_hash, .flag_clear, .hsel, .xlat_out, .parity_err, .untrans_err, .aux_fault_both_low,
  .aux_fault_both_high, .hash_purge, .parity_err_to_positioner, .parity_err_to_rw_flag, .parity_diag_err);

// file: testbench/trc_char_checker_tb_top.sv
`timescale 1ns/1ps

module trc_char_checker_tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, char_valid = 1'b0, one_digit_xlat = 1'b0, check_read = 1'b0;
  logic hash_pulse_period = 1'b0, positioner_attached = 1'b0, classify_info = 1'b0, classify_hash = 1'b0;
  logic flag_clear = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [6:0] tch = 7'h0;
  logic [1:0] fmode = 2'h0, htrans = 2'h0;
  logic [4:0] xlat_in = 5'h0a;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [6:0] char_in;
  logic [4:0] xlat_out;
  logic [31:0] hrdata;
  logic char_check_bit, aux_decode_a, aux_decode_b, parity_err, untrans_err, aux_fault_both_low, hash_purge;
  logic aux_fault_both_high, parity_err_to_positioner, parity_err_to_rw_flag, parity_diag_err, untrans_diag_err;
  logic irq, hreadyout, hresp;
  int err_count = 0;
  int total_checks = 0;
  logic [7:0] ut [7] = '{8'h43, 8'h01, 8'h02, 8'h10, 8'h20, 8'h70, 8'h8d};
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  trc_tape_side u_tape (.tape_char(tch), .fault_mode(fmode), .char_in, .char_check_bit, .aux_decode_a,
    .aux_decode_b);
  trc_char_checker dut (.clk, .rst, .ce, .char_valid, .char_in, .char_check_bit, .aux_decode_a, .aux_decode_b,
    .one_digit_xlat, .check_read, .xlat_in, .hash_pulse_period, .positioner_attached, .classify_info,
    .classify_hash, .flag_clear, .xlat_out, .parity_err, .untrans_err, .aux_fault_both_low, .aux_fault_both_high,
    .hash_purge, .parity_err_to_positioner, .parity_err_to_rw_flag, .parity_diag_err, .untrans_diag_err, .irq,
    .hsel, .haddr, .htrans, .hwrite, .hsize(trc_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata);
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        err_count++;
        $display("[FAIL] %0t bus hang", $time);
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= trc_pkg::HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(a, 1'b0, 32'h0);
    chk(hrdata, e, m);
  endtask
  task automatic chr(input logic [6:0] c);
    @(posedge clk);
    tch <= c;
    char_valid <= 1'b1;
    @(posedge clk);
    char_valid <= 1'b0;
    #1;
  endtask
  // Pulse code: 4 info, 2 hash, 1 clear
  task automatic pulse(input logic [2:0] k);
    @(posedge clk);
    {classify_info, classify_hash, flag_clear} <= k;
    @(posedge clk);
    {classify_info, classify_hash, flag_clear} <= 3'h0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(trc_pkg::OFS_STATUS, 32'h0, "status reset");
    chk(hresp, 1'b0, "okay response");
    rd(trc_pkg::OFS_MASK, 32'h0, "mask reset");
    rd(8'h10, 32'h0, "unmapped read");
    bus(trc_pkg::OFS_MASK, 1'b1, 32'h1);
    for (int i = 0; i < 128; i++) begin
      chr(7'(i));
      chk(parity_err, ~^7'(i), "parity");
    end
    chk(irq, 1'b1, "irq raised");
    rd(trc_pkg::OFS_STATUS, 32'h1, "status parity");
    rd(trc_pkg::OFS_STATUS, 32'h0, "status cleared");
    chk(irq, 1'b0, "irq cleared");
    rd(trc_pkg::OFS_FLAGS, 32'h6, "rw and diag flags");
    pulse(3'h1);
    rd(trc_pkg::OFS_FLAGS, 32'h0, "flags cleared");
    positioner_attached <= 1'b1;
    chr(7'h03);
    rd(trc_pkg::OFS_FLAGS, 32'h5, "positioner flag");
    positioner_attached <= 1'b0;
    bus(trc_pkg::OFS_CTRL, 1'b1, 32'h1);
    rd(trc_pkg::OFS_FLAGS, 32'h0, "ctrl clear");
    for (int f = 1; f < 3; f++) begin
      fmode <= 2'(f);
      chr(7'h01);
      chk({aux_fault_both_high, aux_fault_both_low, parity_err}, {2'(f), 1'b1}, "aux fault");
    end
    fmode <= 2'h0;
    rd(trc_pkg::OFS_STATUS, 32'h5, "status fault");
    one_digit_xlat <= 1'b1;
    foreach (ut[i]) begin
      chr(ut[i][6:0]);
      chk({untrans_err, xlat_out}, {ut[i][7], ut[i][7] ? trc_pkg::PLUS_CODE : 5'h0a}, "untrans");
    end
    bus(trc_pkg::OFS_FLAGS, 1'b0, 32'h0);
    chk(hrdata[3], 1'b1, "untrans diag");
    chk(untrans_diag_err, 1'b1, "untrans diag pin");
    check_read <= 1'b1;
    chr(7'h0d);
    chk(untrans_err, 1'b0, "check read");
    check_read <= 1'b0;
    one_digit_xlat <= 1'b0;
    chr(7'h0d);
    chk(untrans_err, 1'b0, "no translate");
    pulse(3'h1);
    bus(trc_pkg::OFS_MASK, 1'b1, 32'h0);
    hash_pulse_period <= 1'b1;
    chr(7'h03);
    chk(irq, 1'b0, "irq masked");
    rd(trc_pkg::OFS_FLAGS, 32'h10, "hold only");
    hash_pulse_period <= 1'b0;
    pulse(3'h4);
    bus(trc_pkg::OFS_FLAGS, 1'b0, 32'h0);
    chk(hrdata[3:0], 4'h6, "info release");
    pulse(3'h1);
    hash_pulse_period <= 1'b1;
    chr(7'h03);
    pulse(3'h2);
    chk(hash_purge, 1'b1, "purge");
    bus(trc_pkg::OFS_FLAGS, 1'b0, 32'h0);
    chk(hrdata[5:0], 6'h0, "holds cleared");
    tally_and_finish();
  end
endmodule // trc_char_checker_tb_top

// file: testbench/trc_tape_side.sv
`timescale 1ns/1ps

module trc_tape_side (
  input wire logic [6:0] tape_char,
  input wire logic [1:0] fault_mode,
  output logic [6:0] char_in,
  output logic char_check_bit,
  output logic aux_decode_a,
  output logic aux_decode_b
);
  logic mid_row;
  assign mid_row = tape_char[3:0] >= 4'h3 && tape_char[3:0] <= 4'hc;
  assign char_in = tape_char;
  assign char_check_bit = tape_char[6];
  // Decoder pair stays complementary unless a scenario injects a fault
  assign aux_decode_a = fault_mode == 2'h0 ? mid_row : fault_mode[1];
  assign aux_decode_b = fault_mode == 2'h0 ? !mid_row : fault_mode[1];
endmodule // trc_tape_side
